// [design/tld_top.v]
// Purpose: Tributary loopback, loopback request and drop/insert steering
// Assumes: Tributary pins and insert pins are asynchronous and oversampled
// Notes: Internal mux/demux and C-bit signals share mclk_i
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "tld_consts.vh"

module tld_top (
	input wire mclk_i,
	input wire rst_n_i,
	input wire [`TLD_ADDR_W-1:0] addr_i,
	input wire [`TLD_DATA_W-1:0] wdata_i,
	input wire wr_stb_i,
	input wire rd_stb_i,
	output wire [`TLD_DATA_W-1:0] rdata_o,
	output wire irq_o,
	input wire [`TLD_NPORTS-1:0] trib_tx_clk_in_i,
	input wire [`TLD_NPORTS-1:0] trib_tx_data_in_i,
	output wire [`TLD_NPORTS-1:0] trib_rx_clk_out_o,
	output wire [`TLD_NPORTS-1:0] trib_rx_data_out_o,
	input wire [`TLD_NPORTS-1:0] dmx_rx_clk_i,
	input wire [`TLD_NPORTS-1:0] dmx_rx_data_i,
	output wire [`TLD_NPORTS-1:0] mux_tx_clk_o,
	output wire [`TLD_NPORTS-1:0] mux_tx_data_o,
	output wire drop_a_clk_o,
	output wire drop_a_data_o,
	output wire drop_b_clk_o,
	output wire drop_b_data_o,
	input wire insert_a_clk_i,
	input wire insert_a_data_i,
	input wire insert_b_clk_i,
	input wire insert_b_data_i,
	input wire [`TLD_NPORTS-1:0] cbit_stb_i,
	input wire [`TLD_NPORTS-1:0] rx_c1_i,
	input wire [`TLD_NPORTS-1:0] rx_c2_i,
	input wire [`TLD_NPORTS-1:0] rx_c3_i,
	input wire [`TLD_NPORTS-1:0] fmt_c1_i,
	output wire [`TLD_NPORTS-1:0] fmt_c3_o
);
	// Control registers
	reg [`TLD_LO_W-1:0] line_lo_q;
	reg [`TLD_HI_W-1:0] line_hi_q;
	reg [`TLD_LO_W-1:0] diag_lo_q;
	reg [`TLD_HI_W-1:0] diag_hi_q;
	reg [`TLD_LO_W-1:0] gen_lo_q;
	reg [`TLD_HI_W-1:0] gen_hi_q;
	reg [`TLD_SEL_W-1:0] drop_a_sel_q;
	reg [`TLD_SEL_W-1:0] drop_b_sel_q;
	reg [`TLD_SEL_W-1:0] ins_a_sel_q;
	reg [`TLD_SEL_W-1:0] ins_b_sel_q;
	reg [`TLD_CFG_W-1:0] cfg_q;
	reg [`TLD_NPORTS-1:0] ist_q;
	reg [`TLD_NPORTS-1:0] ist_d;
	reg [`TLD_NPORTS-1:0] imsk_q;
	reg [`TLD_DATA_W-1:0] rdata_q;
	reg [`TLD_DATA_W-1:0] rdata_d;

	// Data path registers
	reg [`TLD_NPORTS-1:0] rx_clk_q;
	reg [`TLD_NPORTS-1:0] rx_data_q;
	reg [`TLD_NPORTS-1:0] mux_clk_q;
	reg [`TLD_NPORTS-1:0] mux_data_q;
	reg [`TLD_NPORTS-1:0] fmt_c3_q;
	reg drop_a_clk_q;
	reg drop_a_data_q;
	reg drop_b_clk_q;
	reg drop_b_data_q;

	wire [`TLD_NPORTS-1:0] line_all;
	wire [`TLD_NPORTS-1:0] diag_all;
	wire [`TLD_NPORTS-1:0] gen_all;
	wire [`TLD_NPORTS-1:0] req;
	wire [`TLD_NPORTS-1:0] req_rise;
	wire [`TLD_NPORTS-1:0] ist_clr;
	wire [`TLD_NPORTS-1:0] rx_clk_d;
	wire [`TLD_NPORTS-1:0] rx_data_d;
	wire [`TLD_NPORTS-1:0] mux_clk_d;
	wire [`TLD_NPORTS-1:0] mux_data_d;
	wire [`TLD_NPORTS-1:0] drop_a_hit;
	wire [`TLD_NPORTS-1:0] drop_b_hit;
	wire [`TLD_NPORTS-1:0] tx_clk_s;
	wire [`TLD_NPORTS-1:0] tx_data_s;
	wire ins_a_clk_s;
	wire ins_a_data_s;
	wire ins_b_clk_s;
	wire ins_b_data_s;
	wire e3;
	wire g747;
	wire t1_mode;
	wire loop_timed;
	wire wr_ist_lo;
	wire wr_ist_hi;

	assign e3 = cfg_q[`TLD_CFG_E3];
	assign g747 = cfg_q[`TLD_CFG_G747];
	assign loop_timed = cfg_q[`TLD_CFG_LTM];
	assign t1_mode = ~e3 & ~g747;

	assign line_all = {line_hi_q, line_lo_q};
	assign diag_all = {diag_hi_q, diag_lo_q};
	assign gen_all = {gen_hi_q, gen_lo_q};

	// Pin inputs pass two flops before use
	tld_sync u_sync (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.async_i({insert_b_data_i, insert_b_clk_i, insert_a_data_i, insert_a_clk_i,
			trib_tx_data_in_i, trib_tx_clk_in_i}),
		.sync_o({ins_b_data_s, ins_b_clk_s, ins_a_data_s, ins_a_clk_s,
			tx_data_s, tx_clk_s})
	);

	// Far-end loopback request detection
	tld_c3_detect u_det (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.t1_mode_i(t1_mode),
		.cbit_stb_i(cbit_stb_i),
		.c1_i(rx_c1_i),
		.c2_i(rx_c2_i),
		.c3_i(rx_c3_i),
		.req_o(req),
		.rise_o(req_rise)
	);

	genvar p;
	generate
		for (p = 0; p < `TLD_NPORTS; p = p + 1) begin : g_port
			localparam integer PNUM_I = p + 1;
			localparam [`TLD_SEL_W-1:0] PNUM = PNUM_I[`TLD_SEL_W-1:0];
			wire act;
			wire line_on;
			wire diag_on;
			wire ins_a_on;
			wire ins_b_on;

			assign act = ~(g747 & ((p % `TLD_G747_PERIOD) == `TLD_G747_PERIOD - 1))
				& ~(e3 & (p >= `TLD_E3_FIRST));
			assign line_on = line_all[p] & act;
			assign diag_on = diag_all[p] & act;
			assign ins_a_on = (ins_a_sel_q == PNUM) & act;
			assign ins_b_on = (ins_b_sel_q == PNUM) & act & ~ins_a_on;

			// Transmit toward the multiplexer: insert, then line loopback, then pins
			assign mux_clk_d[p] = ins_a_on ? ins_a_clk_s :
				ins_b_on ? ins_b_clk_s :
				line_on ? dmx_rx_clk_i[p] : tx_clk_s[p];
			assign mux_data_d[p] = ins_a_on ? ins_a_data_s :
				ins_b_on ? ins_b_data_s :
				line_on ? dmx_rx_data_i[p] : tx_data_s[p];

			// Receive toward the line uses the tx pins in diag loopback, not the mux path; loop-timed keeps the demux clock
			assign rx_data_d[p] = diag_on ? tx_data_s[p] : dmx_rx_data_i[p];
			assign rx_clk_d[p] = (diag_on & ~loop_timed) ? tx_clk_s[p] :
				dmx_rx_clk_i[p];

			assign drop_a_hit[p] = (drop_a_sel_q == PNUM) & act;
			assign drop_b_hit[p] = (drop_b_sel_q == PNUM) & act;
		end
	endgenerate

	// Data outputs from flops
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_clk_q <= `TLD_RST_ALL;
			rx_data_q <= `TLD_RST_ALL;
			mux_clk_q <= `TLD_RST_ALL;
			mux_data_q <= `TLD_RST_ALL;
			fmt_c3_q <= `TLD_RST_ALL;
			drop_a_clk_q <= `TLD_RST_BIT;
			drop_a_data_q <= `TLD_RST_BIT;
			drop_b_clk_q <= `TLD_RST_BIT;
			drop_b_data_q <= `TLD_RST_BIT;
		end else begin
			rx_clk_q <= rx_clk_d;
			rx_data_q <= rx_data_d;
			mux_clk_q <= mux_clk_d;
			mux_data_q <= mux_data_d;
			fmt_c3_q <= fmt_c1_i ^ (gen_all & {`TLD_NPORTS{t1_mode}});
			drop_a_clk_q <= |(drop_a_hit & dmx_rx_clk_i);
			drop_a_data_q <= |(drop_a_hit & dmx_rx_data_i);
			drop_b_clk_q <= |(drop_b_hit & dmx_rx_clk_i);
			drop_b_data_q <= |(drop_b_hit & dmx_rx_data_i);
		end
	end

	// Sticky request events, write one to clear, set wins
	assign wr_ist_lo = wr_stb_i & (addr_i == `TLD_OFF_IST_LO);
	assign wr_ist_hi = wr_stb_i & (addr_i == `TLD_OFF_IST_HI);
	assign ist_clr = {wdata_i[`TLD_HI_W-1:0] & {`TLD_HI_W{wr_ist_hi}},
		wdata_i & {`TLD_LO_W{wr_ist_lo}}};

	always @* begin
		ist_d = (ist_q & ~ist_clr) | req_rise;
	end

	// Register writes
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			line_lo_q <= `TLD_RST_LO;
			line_hi_q <= `TLD_RST_HI;
			diag_lo_q <= `TLD_RST_LO;
			diag_hi_q <= `TLD_RST_HI;
			gen_lo_q <= `TLD_RST_LO;
			gen_hi_q <= `TLD_RST_HI;
			drop_a_sel_q <= `TLD_RST_SEL;
			drop_b_sel_q <= `TLD_RST_SEL;
			ins_a_sel_q <= `TLD_RST_SEL;
			ins_b_sel_q <= `TLD_RST_SEL;
			cfg_q <= `TLD_RST_CFG;
			imsk_q <= `TLD_RST_ALL;
			ist_q <= `TLD_RST_ALL;
		end else begin
			ist_q <= ist_d;
			if (wr_stb_i) begin
				case (addr_i)
					`TLD_OFF_LINE_LO: begin
						line_lo_q <= wdata_i;
					end
					`TLD_OFF_LINE_HI: begin
						line_hi_q <= wdata_i[`TLD_HI_W-1:0];
					end
					`TLD_OFF_DIAG_LO: begin
						diag_lo_q <= wdata_i;
					end
					`TLD_OFF_DIAG_HI: begin
						diag_hi_q <= wdata_i[`TLD_HI_W-1:0];
					end
					`TLD_OFF_GEN_LO: begin
						gen_lo_q <= wdata_i;
					end
					`TLD_OFF_GEN_HI: begin
						gen_hi_q <= wdata_i[`TLD_HI_W-1:0];
					end
					`TLD_OFF_DROP: begin
						drop_a_sel_q <= wdata_i[`TLD_SEL_A_LSB +: `TLD_SEL_W];
						drop_b_sel_q <= wdata_i[`TLD_SEL_B_LSB +: `TLD_SEL_W];
					end
					`TLD_OFF_INS: begin
						ins_a_sel_q <= wdata_i[`TLD_SEL_A_LSB +: `TLD_SEL_W];
						ins_b_sel_q <= wdata_i[`TLD_SEL_B_LSB +: `TLD_SEL_W];
					end
					`TLD_OFF_CFG: begin
						cfg_q <= wdata_i[`TLD_CFG_W-1:0];
					end
					`TLD_OFF_IMSK_LO: begin
						imsk_q[`TLD_LO_W-1:0] <= wdata_i;
					end
					`TLD_OFF_IMSK_HI: begin
						imsk_q[`TLD_NPORTS-1:`TLD_LO_W] <= wdata_i[`TLD_HI_W-1:0];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Read mux, unmapped and reserved bits read zero
	always @* begin
		rdata_d = `TLD_RST_DATA;
		case (addr_i)
			`TLD_OFF_LINE_LO: begin
				rdata_d = line_lo_q;
			end
			`TLD_OFF_LINE_HI: begin
				rdata_d[`TLD_HI_W-1:0] = line_hi_q;
			end
			`TLD_OFF_DIAG_LO: begin
				rdata_d = diag_lo_q;
			end
			`TLD_OFF_DIAG_HI: begin
				rdata_d[`TLD_HI_W-1:0] = diag_hi_q;
			end
			`TLD_OFF_GEN_LO: begin
				rdata_d = gen_lo_q;
			end
			`TLD_OFF_GEN_HI: begin
				rdata_d[`TLD_HI_W-1:0] = gen_hi_q;
			end
			`TLD_OFF_REQ_LO: begin
				rdata_d = req[`TLD_LO_W-1:0];
			end
			`TLD_OFF_REQ_HI: begin
				rdata_d[`TLD_HI_W-1:0] = req[`TLD_NPORTS-1:`TLD_LO_W];
			end
			`TLD_OFF_DROP: begin
				rdata_d[`TLD_SEL_A_LSB +: `TLD_SEL_W] = drop_a_sel_q;
				rdata_d[`TLD_SEL_B_LSB +: `TLD_SEL_W] = drop_b_sel_q;
			end
			`TLD_OFF_INS: begin
				rdata_d[`TLD_SEL_A_LSB +: `TLD_SEL_W] = ins_a_sel_q;
				rdata_d[`TLD_SEL_B_LSB +: `TLD_SEL_W] = ins_b_sel_q;
			end
			`TLD_OFF_CFG: begin
				rdata_d[`TLD_CFG_W-1:0] = cfg_q;
			end
			`TLD_OFF_IST_LO: begin
				rdata_d = ist_q[`TLD_LO_W-1:0];
			end
			`TLD_OFF_IST_HI: begin
				rdata_d[`TLD_HI_W-1:0] = ist_q[`TLD_NPORTS-1:`TLD_LO_W];
			end
			`TLD_OFF_IMSK_LO: begin
				rdata_d = imsk_q[`TLD_LO_W-1:0];
			end
			`TLD_OFF_IMSK_HI: begin
				rdata_d[`TLD_HI_W-1:0] = imsk_q[`TLD_NPORTS-1:`TLD_LO_W];
			end
			default: begin
				rdata_d = `TLD_RST_DATA;
			end
		endcase
		if (!rd_stb_i) begin
			rdata_d = `TLD_RST_DATA;
		end
	end

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= `TLD_RST_DATA;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;
	assign irq_o = |(ist_q & imsk_q);
	assign trib_rx_clk_out_o = rx_clk_q;
	assign trib_rx_data_out_o = rx_data_q;
	assign mux_tx_clk_o = mux_clk_q;
	assign mux_tx_data_o = mux_data_q;
	assign fmt_c3_o = fmt_c3_q;
	assign drop_a_clk_o = drop_a_clk_q;
	assign drop_a_data_o = drop_a_data_q;
	assign drop_b_clk_o = drop_b_clk_q;
	assign drop_b_data_o = drop_b_data_q;
endmodule

// [design/tld_consts.vh]
// Purpose: Shared constants for the tributary loopback and drop/insert block
// Assumes: 16-bit register port, byte addresses on 8 bits
// Notes: Definitions only
`ifndef TLD_CONSTS_VH
`define TLD_CONSTS_VH

`define TLD_NPORTS 28
`define TLD_LO_W 16
`define TLD_HI_W 12
`define TLD_ADDR_W 8
`define TLD_DATA_W 16
`define TLD_SEL_W 5
`define TLD_SYNC_W 60

// Register byte offsets
`define TLD_OFF_LINE_LO 8'h50
`define TLD_OFF_LINE_HI 8'h52
`define TLD_OFF_DIAG_LO 8'h54
`define TLD_OFF_DIAG_HI 8'h56
`define TLD_OFF_GEN_LO 8'h58
`define TLD_OFF_GEN_HI 8'h5A
`define TLD_OFF_REQ_LO 8'h5C
`define TLD_OFF_REQ_HI 8'h5E
`define TLD_OFF_DROP 8'h60
`define TLD_OFF_INS 8'h62
`define TLD_OFF_CFG 8'h64
`define TLD_OFF_IST_LO 8'h68
`define TLD_OFF_IST_HI 8'h6A
`define TLD_OFF_IMSK_LO 8'h6C
`define TLD_OFF_IMSK_HI 8'h6E

// Field positions
`define TLD_SEL_A_LSB 0
`define TLD_SEL_B_LSB 8
`define TLD_CFG_E3 0
`define TLD_CFG_G747 1
`define TLD_CFG_LTM 2
`define TLD_CFG_W 3

// Port activity pattern
`define TLD_G747_PERIOD 4
`define TLD_E3_FIRST 16

// Reset values
`define TLD_RST_LO 16'h0000
`define TLD_RST_HI 12'h000
`define TLD_RST_ALL 28'h000_0000
`define TLD_RST_SEL 5'h00
`define TLD_RST_CFG 3'h0
`define TLD_RST_DATA 16'h0000
`define TLD_RST_BIT 1'b0

`endif

// [design/tld_sync.v]
// Purpose: Two-flop synchroniser bank for pin inputs
// Assumes: Inputs asynchronous to mclk_i
// Notes: First stage is read only by the second
`timescale 1ns/1ps
`include "tld_consts.vh"

module tld_sync (
	input wire mclk_i,
	input wire rst_n_i,
	input wire [`TLD_SYNC_W-1:0] async_i,
	output wire [`TLD_SYNC_W-1:0] sync_o
);
	reg [`TLD_SYNC_W-1:0] meta_q;
	reg [`TLD_SYNC_W-1:0] sync_q;

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= {`TLD_SYNC_W{`TLD_RST_BIT}};
			sync_q <= {`TLD_SYNC_W{`TLD_RST_BIT}};
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule

// [design/tld_c3_detect.v]
// Purpose: Per-line detection of an inverted C3 bit
// Assumes: Strobe marks a line's C1..C3 as valid, same clock domain
// Notes: Request level follows each new C-bit group in T1 mode, held low otherwise
`timescale 1ns/1ps
`include "tld_consts.vh"

module tld_c3_detect (
	input wire mclk_i,
	input wire rst_n_i,
	input wire t1_mode_i,
	input wire [`TLD_NPORTS-1:0] cbit_stb_i,
	input wire [`TLD_NPORTS-1:0] c1_i,
	input wire [`TLD_NPORTS-1:0] c2_i,
	input wire [`TLD_NPORTS-1:0] c3_i,
	output wire [`TLD_NPORTS-1:0] req_o,
	output wire [`TLD_NPORTS-1:0] rise_o
);
	reg [`TLD_NPORTS-1:0] req_q;
	reg [`TLD_NPORTS-1:0] req_d;
	wire [`TLD_NPORTS-1:0] inv;

	// C3 against agreeing C1 and C2
	assign inv = (c1_i ~^ c2_i) & (c3_i ^ c1_i);

	always @* begin
		req_d = (req_q & ~cbit_stb_i) | (inv & cbit_stb_i);
		if (!t1_mode_i) begin
			req_d = `TLD_RST_ALL;
		end
	end

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_q <= `TLD_RST_ALL;
		end else begin
			req_q <= req_d;
		end
	end

	assign req_o = req_q;
	assign rise_o = req_d & ~req_q;
endmodule

// [test/tld_monitor.sv]
// Purpose: Port-level checks of the tributary loopback block
// Assumes: Register state mirrored from the write strobe
// Notes: Bound into every tld_top
`timescale 1ns/1ps
`include "tld_consts.vh"

module tld_monitor (
	input wire mclk_i,
	input wire rst_n_i,
	input wire [7:0] addr_i,
	input wire [15:0] wdata_i,
	input wire wr_stb_i,
	input wire rd_stb_i,
	input wire [15:0] rdata_o,
	input wire irq_o,
	input wire [27:0] trib_tx_data_in_i,
	input wire [27:0] trib_rx_clk_out_o,
	input wire [27:0] trib_rx_data_out_o,
	input wire [27:0] dmx_rx_clk_i,
	input wire [27:0] dmx_rx_data_i,
	input wire [27:0] mux_tx_data_o,
	input wire drop_a_data_o,
	input wire insert_a_data_i,
	input wire [27:0] cbit_stb_i,
	input wire [27:0] rx_c1_i,
	input wire [27:0] rx_c2_i,
	input wire [27:0] rx_c3_i,
	input wire [27:0] fmt_c1_i,
	input wire [27:0] fmt_c3_o
);
	reg [27:0] line_q, diag_q, gen_q;
	reg [15:0] drp_q, ins_q;
	reg [2:0] cfg_q;
	wire [27:0] act;
	wire t1 = !cfg_q[0] && !cfg_q[1];
	wire [4:0] da = drp_q[4:0];
	wire [4:0] ia = ins_q[4:0];
	wire da_ok = da != 5'h00 && da <= 5'h1C && act[da - 5'h01];
	wire ia_ok = ia != 5'h00 && ia <= 5'h1C && act[ia - 5'h01];
	wire da_bit = dmx_rx_data_i[da - 5'h01];
	wire ia_out = mux_tx_data_o[ia - 5'h01];
	wire det = t1 && |(cbit_stb_i & ~(rx_c1_i ^ rx_c2_i) & (rx_c3_i ^ rx_c1_i));

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			line_q <= 28'h000_0000;
			diag_q <= 28'h000_0000;
			gen_q <= 28'h000_0000;
			drp_q <= 16'h0000;
			ins_q <= 16'h0000;
			cfg_q <= 3'h0;
		end else if (wr_stb_i) begin
			case (addr_i)
				`TLD_OFF_LINE_LO: line_q[15:0] <= wdata_i;
				`TLD_OFF_LINE_HI: line_q[27:16] <= wdata_i[11:0];
				`TLD_OFF_DIAG_LO: diag_q[15:0] <= wdata_i;
				`TLD_OFF_DIAG_HI: diag_q[27:16] <= wdata_i[11:0];
				`TLD_OFF_GEN_LO: gen_q[15:0] <= wdata_i;
				`TLD_OFF_GEN_HI: gen_q[27:16] <= wdata_i[11:0];
				`TLD_OFF_DROP: drp_q <= wdata_i;
				`TLD_OFF_INS: ins_q <= wdata_i;
				`TLD_OFF_CFG: cfg_q <= wdata_i[2:0];
				default: ;
			endcase
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	genvar p;
	generate
		for (p = 0; p < 28; p = p + 1) begin : g_port
			wire on = !(cfg_q[1] && (p % 4) == 3) && !(cfg_q[0] && p >= 16);
			wire hit = ia == p + 1 || ins_q[12:8] == p + 1;
			wire dl = diag_q[p] && on;
			assign act[p] = on;
			AST_LINE_LOOP: assert property (line_q[p] && on && !hit |->
				##1 mux_tx_data_o[p] == $past(dmx_rx_data_i[p])) else $error("line loop wrong");
			AST_DIAG_LOOP: assert property (dl |->
				##1 trib_rx_data_out_o[p] == $past(trib_tx_data_in_i[p], 3)) else $error("diag wrong");
			AST_RX_NORMAL: assert property (!dl |->
				##1 trib_rx_data_out_o[p] == $past(dmx_rx_data_i[p])) else $error("rx path wrong");
			AST_TIMED_CLK: assert property (dl && cfg_q[2] |->
				##1 trib_rx_clk_out_o[p] == $past(dmx_rx_clk_i[p])) else $error("rx clock looped");
		end
	endgenerate

	sequence s_ins_held;
		ia_ok ##1 (ia_ok && $stable(ins_q));
	endsequence

	AST_INSERT_A: assert property (s_ins_held |-> ia_out == $past(insert_a_data_i, 3))
		else $error("insert A not taken");
	AST_DROP_A: assert property (da_ok |=> drop_a_data_o == $past(da_bit))
		else $error("drop A wrong");
	AST_READ_DIAG: assert property (rd_stb_i && addr_i == `TLD_OFF_DIAG_LO |=>
		rdata_o == $past(diag_q[15:0])) else $error("diag register read wrong");
	AST_FMT_C3: assert property ($past(rst_n_i) |->
		fmt_c3_o == $past(fmt_c1_i ^ (gen_q & {28{t1}}))) else $error("c3 output wrong");
	AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> $past(det || wr_stb_i))
		else $error("irq without cause");
endmodule

bind tld_top tld_monitor i_mon (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .rdata_o(rdata_o),
	.irq_o(irq_o), .trib_tx_data_in_i(trib_tx_data_in_i),
	.trib_rx_clk_out_o(trib_rx_clk_out_o), .trib_rx_data_out_o(trib_rx_data_out_o),
	.dmx_rx_clk_i(dmx_rx_clk_i), .dmx_rx_data_i(dmx_rx_data_i), .mux_tx_data_o(mux_tx_data_o),
	.drop_a_data_o(drop_a_data_o), .insert_a_data_i(insert_a_data_i), .cbit_stb_i(cbit_stb_i),
	.rx_c1_i(rx_c1_i), .rx_c2_i(rx_c2_i), .rx_c3_i(rx_c3_i), .fmt_c1_i(fmt_c1_i),
	.fmt_c3_o(fmt_c3_o));

// [test/tld_line_partner.sv]
// Purpose: Tributary equipment and demultiplexer stand-in
// Assumes: One pattern word drives both directions
// Notes: Each tx source differs from its demultiplexer counterpart so a wrong path shows
`timescale 1ns/1ps

module tld_line_partner (
	input wire [27:0] pat_i,
	output wire [27:0] tx_clk_o,
	output wire [27:0] tx_data_o,
	output wire [27:0] dmx_clk_o,
	output wire [27:0] dmx_data_o
);
	assign tx_clk_o = pat_i;
	assign tx_data_o = ~pat_i;
	assign dmx_clk_o = ~pat_i;
	assign dmx_data_o = pat_i;
endmodule

// [test/tld_top_tb_top.sv]
// Purpose: Self-checking bench of the tributary loopback block
// Assumes: 40 MHz clock, four-cycle reset
// Notes: Pin paths settle within five cycles
`timescale 1ns/1ps
`include "tld_consts.vh"
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin n_errors++; \
	$display("Error %s expected %h seen %h", nm, ex, gt); end end

module tld_top_tb_top;
	localparam [27:0] ONES = 28'hFFF_FFFF;
	localparam [27:0] P = 28'h5A3_C96F;
	reg mclk_i = 1'b0;
	reg rst_n_i = 1'b0;
	reg [7:0] addr_i = 8'h00;
	reg [15:0] wdata_i = 16'h0000;
	reg wr_stb_i = 1'b0;
	reg rd_stb_i = 1'b0;
	reg [27:0] pat = 28'h000_0000;
	reg ins_a = 1'b0;
	reg ins_b = 1'b0;
	reg [27:0] cbit_stb_i = 28'h000_0000;
	reg [27:0] rx_c2_i = ONES;
	reg [27:0] rx_c3_i = ONES;
	reg [15:0] d;
	wire [15:0] rdata_o;
	wire irq_o, da_clk, da_dat, db_clk, db_dat;
	wire [27:0] tx_clk, tx_dat, rx_clk, rx_dat, dmx_clk, dmx_dat, mux_clk, mux_dat, fmt_c3;
	int n_errors = 0;
	int total_checks = 0;
	logic [15:0] cfg_t [4] = '{16'h0004, 16'h0002, 16'h0001, 16'h0006};
	logic [27:0] mux_t [4] = '{28'h000_0000, 28'h888_8888, 28'hFFF_0000, 28'h888_8888};
	logic [27:0] rxd_t [4] = '{28'h001_A5A5, 28'h001_2525, 28'h000_A5A5, 28'h001_2525};
	logic [27:0] rxc_t [4] = '{28'h000_0000, 28'h001_2525, 28'h000_A5A5, 28'h000_0000};

	always #12.5 mclk_i = ~mclk_i;

	tld_line_partner i_far (.pat_i(pat), .tx_clk_o(tx_clk), .tx_data_o(tx_dat),
		.dmx_clk_o(dmx_clk), .dmx_data_o(dmx_dat));

	tld_top i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .rdata_o(rdata_o), .irq_o(irq_o),
		.trib_tx_clk_in_i(tx_clk), .trib_tx_data_in_i(tx_dat), .trib_rx_clk_out_o(rx_clk),
		.trib_rx_data_out_o(rx_dat), .dmx_rx_clk_i(dmx_clk), .dmx_rx_data_i(dmx_dat),
		.mux_tx_clk_o(mux_clk), .mux_tx_data_o(mux_dat), .drop_a_clk_o(da_clk),
		.drop_a_data_o(da_dat), .drop_b_clk_o(db_clk), .drop_b_data_o(db_dat),
		.insert_a_clk_i(~ins_a), .insert_a_data_i(ins_a), .insert_b_clk_i(~ins_b),
		.insert_b_data_i(ins_b), .cbit_stb_i(cbit_stb_i), .rx_c1_i(ONES), .rx_c2_i(rx_c2_i),
		.rx_c3_i(rx_c3_i), .fmt_c1_i(pat), .fmt_c3_o(fmt_c3));

	task automatic wr(input [7:0] a, input [15:0] v);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_stb_i <= 1'b1;
		@(posedge mclk_i);
		wr_stb_i <= 1'b0;
	endtask

	task automatic rchk(input [7:0] a, input [15:0] ex, input string nm);
		@(posedge mclk_i);
		addr_i <= a;
		rd_stb_i <= 1'b1;
		@(posedge mclk_i);
		rd_stb_i <= 1'b0;
		#1 d = rdata_o;
		`CHK(nm, ex, d)
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic summarize;
		if (n_errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#100us;
		n_errors++;
		summarize;
	end

	initial begin
		repeat (4) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		rchk(`TLD_OFF_LINE_LO, 16'h0000, "line_lo");
		rchk(`TLD_OFF_DIAG_LO, 16'h0000, "diag_lo");
		wr(`TLD_OFF_LINE_HI, 16'hFFFF);
		rchk(`TLD_OFF_LINE_HI, 16'h0FFF, "line_hi");
		wr(`TLD_OFF_LINE_LO, 16'hFFFF);
		wr(`TLD_OFF_DIAG_LO, 16'hA5A5);
		wr(`TLD_OFF_DIAG_HI, 16'h0001);
		rchk(`TLD_OFF_DIAG_LO, 16'hA5A5, "diag_lo");
		wr(8'h4E, 16'hFFFF);
		rchk(8'h4E, 16'h0000, "unmapped");
		@(posedge mclk_i) pat <= P;
		wt(5);
		`CHK("mux data", P, mux_dat)
		`CHK("mux clk", ~P, mux_clk)
		`CHK("rx data", P ^ 28'h001_A5A5, rx_dat)
		`CHK("rx clk", ~P ^ 28'h001_A5A5, rx_clk)
		for (int i = 0; i < 4; i++) begin
			wr(`TLD_OFF_CFG, cfg_t[i]);
			wt(2);
			`CHK("mode mux", P ^ mux_t[i], mux_dat)
			`CHK("mode rx", P ^ rxd_t[i], rx_dat)
			`CHK("mode clk", ~P ^ rxc_t[i], rx_clk)
		end
		wr(`TLD_OFF_CFG, 16'h0000);
		wr(`TLD_OFF_DIAG_LO, 16'h0000);
		wr(`TLD_OFF_DROP, 16'h1405);
		wr(`TLD_OFF_INS, 16'h0203);
		@(posedge mclk_i) ins_a <= 1'b1;
		wt(5);
		`CHK("drop", {~P[4], P[4], ~P[19], P[19]}, {da_clk, da_dat, db_clk, db_dat})
		`CHK("rx kept", P ^ 28'h001_0000, rx_dat)
		`CHK("ins data", (P & ~28'h000_0006) | 28'h000_0004, mux_dat)
		`CHK("ins clk", (~P & ~28'h000_0006) | 28'h000_0002, mux_clk)
		wr(`TLD_OFF_IMSK_LO, 16'h0004);
		@(posedge mclk_i);
		cbit_stb_i <= 28'h002_0014;
		rx_c2_i <= ONES ^ 28'h000_0010;
		rx_c3_i <= ONES ^ 28'h002_0014;
		@(posedge mclk_i);
		cbit_stb_i <= 28'h000_0000;
		wt(1);
		`CHK("irq set", 1'b1, irq_o)
		rchk(`TLD_OFF_REQ_LO, 16'h0004, "req lo");
		rchk(`TLD_OFF_REQ_HI, 16'h0002, "req hi");
		wr(`TLD_OFF_LINE_LO, 16'h0004);
		wr(`TLD_OFF_IST_LO, 16'h0004);
		wt(1);
		`CHK("irq clear", 1'b0, irq_o)
		rchk(`TLD_OFF_IST_HI, 16'h0002, "sticky hi");
		wr(`TLD_OFF_CFG, 16'h0001);
		wt(2);
		rchk(`TLD_OFF_REQ_LO, 16'h0000, "req e3");
		wr(`TLD_OFF_GEN_LO, 16'h0001);
		wr(`TLD_OFF_GEN_HI, 16'h0800);
		wt(1);
		`CHK("c3 e3", P, fmt_c3)
		wr(`TLD_OFF_CFG, 16'h0000);
		wt(1);
		`CHK("c3 gen", P ^ 28'h800_0001, fmt_c3)
		wr(`TLD_OFF_GEN_LO, 16'h0000);
		wr(`TLD_OFF_GEN_HI, 16'h0000);
		wt(1);
		`CHK("c3 idle", P, fmt_c3)
		summarize;
	end
endmodule
